// file: inc/usc_map.vh
// Register map, field positions and timing constants of the serial transceiver
`ifndef USC_MAP_VH
`define USC_MAP_VH
// Byte offsets on the register bus
`define USC_OFF_MODE 5'h00
`define USC_OFF_STA 5'h04
`define USC_OFF_TXD 5'h08
`define USC_OFF_RXD 5'h0c
`define USC_OFF_BAUD 5'h10
// Mode register fields
`define USC_MODE_STOP 0
`define USC_MODE_FMT_LO 1
`define USC_MODE_FMT_HI 2
`define USC_MODE_HSPD 3
`define USC_MODE_INFRARED_CODEC_EN 12
// Status and control register fields
`define USC_STA_TXSEL1 15
`define USC_STA_TX_POLARITY_INVERT 14
`define USC_STA_TXSEL0 13
`define USC_STA_BRK 11
`define USC_STA_TXEN 10
`define USC_STA_TXFULL 9
`define USC_STA_TXEMPTY 8
`define USC_STA_RXSEL1 7
`define USC_STA_RXSEL0 6
`define USC_STA_ADDRESS_DETECT_EN 5
`define USC_STA_RX_IDLE 4
`define USC_STA_PARITY_ERROR 3
`define USC_STA_FRAMING_ERROR 2
`define USC_STA_OVERRUN_ERROR 1
`define USC_STA_RXDA 0
// Frame format codes
`define USC_FMT_9N 2'h3
`define USC_FMT_8O 2'h2
`define USC_FMT_8E 2'h1
`define USC_FMT_8N 2'h0
// Transmit event select codes
`define USC_TXI_EVERY 2'h0
`define USC_TXI_DONE 2'h1
`define USC_TXI_EMPTY 2'h2
// Receive event select codes and the level-3 buffer count
`define USC_RXI_FULL 2'h3
`define USC_RXI_3Q 2'h2
`define USC_RX_LVL3 3'h3
// Timing counts and the break frame pattern
`define USC_SPB_STD 5'h10
`define USC_SPB_HS 5'h04
`define USC_IR_PULSE 5'h03
`define USC_BASE_BITS 4'ha
`define USC_BRK_LEN 4'he
`define USC_BRK_FRAME 15'h6000
`define USC_DATA8 4'h8
`define USC_BAUD_RST 16'h0000
`endif

// file: hw/usc_tx.v
// Transmit shifter with frame builder and break generator
`timescale 1ns/1ns
`include "usc_map.vh"
module usc_tx (
   input wire i_mclk,
   input wire i_rstn,
   input wire i_tick,
   input wire [4:0] i_spb,
   input wire i_abort,
   input wire i_valid,
   input wire [8:0] i_data,
   input wire [1:0] i_fmt,
   input wire i_stop2,
   input wire i_break,
   output wire o_ready,
   output wire o_line,
   output wire [4:0] o_phase,
   output wire o_busy,
   output reg o_load,
   output reg o_done,
   output reg o_brk_done
);
   reg busy_r;
   reg brk_r;
   reg [14:0] sh_r;
   reg [3:0] bits_r;
   reg [4:0] ph_r;
   wire nine = (i_fmt == `USC_FMT_9N);
   wire par_on = (i_fmt == `USC_FMT_8O) || (i_fmt == `USC_FMT_8E);
   wire par_bit = (i_fmt == `USC_FMT_8O) ? ~^i_data[7:0] : ^i_data[7:0];
   wire [8:0] payload = nine ? i_data : (par_on ? {par_bit, i_data[7:0]} : {1'b1, i_data[7:0]});
   wire [3:0] len = `USC_BASE_BITS + {3'h0, nine | par_on} + {3'h0, i_stop2};
   assign o_ready = ~busy_r & ~i_abort;
   assign o_line = busy_r ? sh_r[0] : 1'b1;
   assign o_phase = ph_r;
   assign o_busy = busy_r;
   always @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         busy_r <= 1'b0;
         brk_r <= 1'b0;
         sh_r <= 15'h7fff;
         bits_r <= 4'h0;
         ph_r <= 5'h00;
         o_load <= 1'b0;
         o_done <= 1'b0;
         o_brk_done <= 1'b0;
      end else begin
         o_load <= 1'b0;
         o_done <= 1'b0;
         o_brk_done <= 1'b0;
         if (i_abort) begin
            busy_r <= 1'b0;
            ph_r <= 5'h00;
         end else if (!busy_r) begin
            if (i_valid) begin
               busy_r <= 1'b1;
               brk_r <= i_break;
               ph_r <= 5'h00;
               o_load <= 1'b1;
               if (i_break) begin
                  sh_r <= `USC_BRK_FRAME;
                  bits_r <= `USC_BRK_LEN;
               end else begin
                  sh_r <= {5'h1f, payload, 1'b0};
                  bits_r <= len;
               end
            end
         end else if (i_tick) begin
            if (ph_r == i_spb - 5'h01) begin
               ph_r <= 5'h00;
               sh_r <= {1'b1, sh_r[14:1]};
               bits_r <= bits_r - 4'h1;
               if (bits_r == 4'h1) begin
                  busy_r <= 1'b0;
                  o_done <= 1'b1;
                  o_brk_done <= brk_r;
               end
            end else begin
               ph_r <= ph_r + 5'h01;
            end
         end
      end
   end
endmodule

// file: hw/usc_rx.v
// Receive sampler with infrared pulse decoding and error checks
`timescale 1ns/1ns
`include "usc_map.vh"
module usc_rx (
   input wire i_mclk,
   input wire i_rstn,
   input wire i_tick,
   input wire [4:0] i_spb,
   input wire i_abort,
   input wire i_line,
   input wire i_ir,
   input wire [1:0] i_fmt,
   output wire o_idle,
   output reg o_done,
   output reg [8:0] o_data,
   output reg o_parity_error,
   output reg o_framing_error
);
   localparam S_IDLE = 4'b0001;
   localparam S_START = 4'b0010;
   localparam S_DATA = 4'b0100;
   localparam S_STOP = 4'b1000;
   reg [3:0] st_r;
   reg [4:0] ph_r;
   reg [3:0] cnt_r;
   reg [8:0] sh_r;
   reg low_r;
   wire nine = (i_fmt == `USC_FMT_9N);
   wire wide = nine || (i_fmt == `USC_FMT_8O) || (i_fmt == `USC_FMT_8E);
   wire [3:0] nbits = `USC_DATA8 + {3'h0, wide};
   wire bound = (ph_r == i_spb - 5'h01);
   wire bitv = i_ir ? ~(low_r | ~i_line) : i_line;
   wire samp = i_tick && (i_ir ? bound : (ph_r == {1'b0, i_spb[4:1]}));
   wire parity_error = (i_fmt == `USC_FMT_8O) ? ~^sh_r : ((i_fmt == `USC_FMT_8E) ? ^sh_r : 1'b0);
   assign o_idle = (st_r == S_IDLE);
   always @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_r <= S_IDLE;
         ph_r <= 5'h00;
         cnt_r <= 4'h0;
         sh_r <= 9'h000;
         low_r <= 1'b0;
         o_done <= 1'b0;
         o_data <= 9'h000;
         o_parity_error <= 1'b0;
         o_framing_error <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_abort) begin
            st_r <= S_IDLE;
         end else if (st_r == S_IDLE) begin
            if (!i_line) begin
               st_r <= S_START;
               ph_r <= 5'h00;
               low_r <= 1'b1;
            end
         end else if (i_tick) begin
            ph_r <= bound ? 5'h00 : ph_r + 5'h01;
            low_r <= bound ? 1'b0 : (low_r | ~i_line);
            if (samp) begin
               case (st_r)
                  S_START: begin
                     st_r <= bitv ? S_IDLE : S_DATA;
                     cnt_r <= 4'h0;
                  end
                  S_DATA: begin
                     sh_r[cnt_r] <= bitv;
                     cnt_r <= cnt_r + 4'h1;
                     if (cnt_r == nbits - 4'h1) begin
                        st_r <= S_STOP;
                     end
                  end
                  S_STOP: begin
                     st_r <= S_IDLE;
                     o_done <= 1'b1;
                     o_data <= nine ? sh_r : {1'b0, sh_r[7:0]};
                     o_parity_error <= parity_error;
                     o_framing_error <= ~bitv;
                  end
                  default: begin
                     st_r <= S_IDLE;
                  end
               endcase
            end
         end
      end
   end
endmodule

// file: hw/usc_top.v
// Serial transceiver top: bus slave, registers, buffers, baud and pin logic
`timescale 1ns/1ns
`include "usc_map.vh"
module usc_top #(
   parameter FIFO_AW = 2
) (
   input wire i_mclk,
   input wire i_resetn,
   input wire [4:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   output reg [31:0] o_avs_readdata,
   output reg o_avs_waitrequest,
   input wire i_rx,
   output reg o_tx,
   output reg o_tx_oe,
   output reg o_tx_irq,
   output reg o_rx_irq
);
   localparam DEPTH = 1 << FIFO_AW;
   localparam [FIFO_AW:0] FULL_C = {1'b1, {FIFO_AW{1'b0}}};
   localparam [FIFO_AW:0] LVL3_C = `USC_RX_LVL3;
   localparam [FIFO_AW:0] ZERO_C = {(FIFO_AW + 1){1'b0}};
   reg rst_meta_r;
   reg rst_sync_r;
   wire rstn = rst_sync_r;
   always @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end
   // Control state
   reg infrared_codec_en_r, hspd_r, stop2_r, tx_polarity_invert_r, brk_r, txen_r, address_detect_en_r, overrun_error_r;
   reg [1:0] fmt_r, txsel_r, rxsel_r;
   reg [15:0] baud_r, bcnt_r;
   reg pop_ok_r;
   // Buffers
   reg [8:0] txm [0:DEPTH-1];
   reg [10:0] rxm [0:DEPTH-1];
   reg [FIFO_AW-1:0] twp_r, trp_r, rwp_r, rrp_r;
   reg [FIFO_AW:0] tcnt_r, rcnt_r;
   // Bus strobes at the completing edge
   wire busreq = i_avs_read | i_avs_write;
   wire wr = i_avs_write & ~o_avs_waitrequest;
   wire rd = i_avs_read & ~o_avs_waitrequest;
   wire [31:0] wd = i_avs_writedata;
   wire wr_mode = wr && (i_avs_address == `USC_OFF_MODE);
   wire wr_sta = wr && (i_avs_address == `USC_OFF_STA);
   wire wr_txd = wr && (i_avs_address == `USC_OFF_TXD);
   wire wr_baud = wr && (i_avs_address == `USC_OFF_BAUD);
   wire rd_rxd = rd && (i_avs_address == `USC_OFF_RXD);
   // Baud and line timing
   wire tick = (bcnt_r == baud_r);
   wire [4:0] spb = hspd_r ? `USC_SPB_HS : `USC_SPB_STD;
   wire ir_act = infrared_codec_en_r & ~hspd_r;
   // Submodule links
   wire tx_ready, tx_line, tx_busy, tx_load, tx_done, tx_brk_done;
   wire [4:0] tx_phase;
   wire rx_idle, rx_done, rx_parity_error, rx_framing_error;
   wire [8:0] rx_data;
   wire tx_flush = wr_sta & ~wd[`USC_STA_TXEN] & txen_r;
   wire tx_valid = txen_r & tx_ready & (tcnt_r != ZERO_C);
   wire brk_live = brk_r & ~tx_brk_done;
   wire tx_push = wr_txd & (tcnt_r != FULL_C);
   wire tx_pop = tx_load;
   wire [FIFO_AW:0] tcnt_aft = tcnt_r + {{FIFO_AW{1'b0}}, tx_push} - {{FIFO_AW{1'b0}}, tx_pop};
   wire rx_pop = rd_rxd & pop_ok_r;
   wire rx_keep = ~(address_detect_en_r & (fmt_r == `USC_FMT_9N) & ~rx_data[8]);
   wire rx_room = (rcnt_r != FULL_C) | rx_pop;
   wire rx_ovf = rx_done & rx_keep & ~overrun_error_r & ~rx_room;
   wire rx_push = rx_done & rx_keep & ~overrun_error_r & rx_room;
   wire overrun_error_clr = wr_sta & ~wd[`USC_STA_OVERRUN_ERROR] & overrun_error_r;
   wire rx_flush = overrun_error_clr & ~rx_ovf;
   wire [FIFO_AW:0] rcnt_aft = rcnt_r + {{FIFO_AW{1'b0}}, rx_push} - {{FIFO_AW{1'b0}}, rx_pop};
   wire [10:0] rx_top = rxm[rrp_r];
   usc_tx u_tx (
      .i_mclk(i_mclk),
      .i_rstn(rstn),
      .i_tick(tick),
      .i_spb(spb),
      .i_abort(tx_flush),
      .i_valid(tx_valid),
      .i_data(txm[trp_r]),
      .i_fmt(fmt_r),
      .i_stop2(stop2_r),
      .i_break(brk_live),
      .o_ready(tx_ready),
      .o_line(tx_line),
      .o_phase(tx_phase),
      .o_busy(tx_busy),
      .o_load(tx_load),
      .o_done(tx_done),
      .o_brk_done(tx_brk_done)
   );
   usc_rx u_rx (
      .i_mclk(i_mclk),
      .i_rstn(rstn),
      .i_tick(tick),
      .i_spb(spb),
      .i_abort(rx_flush),
      .i_line(i_rx),
      .i_ir(ir_act),
      .i_fmt(fmt_r),
      .o_idle(rx_idle),
      .o_done(rx_done),
      .o_data(rx_data),
      .o_parity_error(rx_parity_error),
      .o_framing_error(rx_framing_error)
   );
   // Read data mux
   reg [31:0] rd_nxt;
   always @* begin
      rd_nxt = 32'h00000000;
      case (i_avs_address)
         `USC_OFF_MODE: begin
            rd_nxt[`USC_MODE_INFRARED_CODEC_EN] = infrared_codec_en_r;
            rd_nxt[`USC_MODE_HSPD] = hspd_r;
            rd_nxt[`USC_MODE_FMT_HI:`USC_MODE_FMT_LO] = fmt_r;
            rd_nxt[`USC_MODE_STOP] = stop2_r;
         end
         `USC_OFF_STA: begin
            rd_nxt[`USC_STA_TXSEL1] = txsel_r[1];
            rd_nxt[`USC_STA_TX_POLARITY_INVERT] = tx_polarity_invert_r;
            rd_nxt[`USC_STA_TXSEL0] = txsel_r[0];
            rd_nxt[`USC_STA_BRK] = brk_r;
            rd_nxt[`USC_STA_TXEN] = txen_r;
            rd_nxt[`USC_STA_TXFULL] = (tcnt_r == FULL_C);
            rd_nxt[`USC_STA_TXEMPTY] = (tcnt_r == ZERO_C) & ~tx_busy;
            rd_nxt[`USC_STA_RXSEL1] = rxsel_r[1];
            rd_nxt[`USC_STA_RXSEL0] = rxsel_r[0];
            rd_nxt[`USC_STA_ADDRESS_DETECT_EN] = address_detect_en_r;
            rd_nxt[`USC_STA_RX_IDLE] = rx_idle;
            rd_nxt[`USC_STA_PARITY_ERROR] = (rcnt_r != ZERO_C) & rx_top[1];
            rd_nxt[`USC_STA_FRAMING_ERROR] = (rcnt_r != ZERO_C) & rx_top[0];
            rd_nxt[`USC_STA_OVERRUN_ERROR] = overrun_error_r;
            rd_nxt[`USC_STA_RXDA] = (rcnt_r != ZERO_C);
         end
         `USC_OFF_RXD: begin
            rd_nxt[8:0] = (rcnt_r != ZERO_C) ? rx_top[10:2] : 9'h000;
         end
         `USC_OFF_BAUD: begin
            rd_nxt[15:0] = baud_r;
         end
         default: begin
            rd_nxt = 32'h00000000;
         end
      endcase
   end
   // Bus slave: one wait state per access
   always @(posedge i_mclk or negedge rstn) begin
      if (!rstn) begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= 32'h00000000;
         pop_ok_r <= 1'b0;
      end else begin
         o_avs_waitrequest <= ~(busreq & o_avs_waitrequest);
         if (i_avs_read & o_avs_waitrequest) begin
            o_avs_readdata <= rd_nxt;
            pop_ok_r <= (rcnt_r != ZERO_C);
         end
      end
   end
   // Registers
   always @(posedge i_mclk or negedge rstn) begin
      if (!rstn) begin
         infrared_codec_en_r <= 1'b0;
         hspd_r <= 1'b0;
         fmt_r <= `USC_FMT_8N;
         stop2_r <= 1'b0;
         txsel_r <= `USC_TXI_EVERY;
         tx_polarity_invert_r <= 1'b0;
         brk_r <= 1'b0;
         txen_r <= 1'b0;
         rxsel_r <= 2'h0;
         address_detect_en_r <= 1'b0;
         overrun_error_r <= 1'b0;
         baud_r <= `USC_BAUD_RST;
         bcnt_r <= `USC_BAUD_RST;
      end else begin
         bcnt_r <= (tick | wr_baud) ? `USC_BAUD_RST : bcnt_r + 16'h0001;
         if (wr_baud) begin
            baud_r <= wd[15:0];
         end
         if (wr_mode) begin
            infrared_codec_en_r <= wd[`USC_MODE_INFRARED_CODEC_EN];
            hspd_r <= wd[`USC_MODE_HSPD];
            fmt_r <= wd[`USC_MODE_FMT_HI:`USC_MODE_FMT_LO];
            stop2_r <= wd[`USC_MODE_STOP];
         end
         if (wr_sta) begin
            txsel_r <= {wd[`USC_STA_TXSEL1], wd[`USC_STA_TXSEL0]};
            tx_polarity_invert_r <= wd[`USC_STA_TX_POLARITY_INVERT];
            brk_r <= wd[`USC_STA_BRK];
            txen_r <= wd[`USC_STA_TXEN];
            rxsel_r <= {wd[`USC_STA_RXSEL1], wd[`USC_STA_RXSEL0]};
            address_detect_en_r <= wd[`USC_STA_ADDRESS_DETECT_EN];
         end else if (tx_brk_done) begin
            brk_r <= 1'b0;
         end
         if (rx_ovf) begin
            overrun_error_r <= 1'b1;
         end else if (overrun_error_clr) begin
            overrun_error_r <= 1'b0;
         end
      end
   end
   // Buffers
   always @(posedge i_mclk or negedge rstn) begin
      if (!rstn) begin
         twp_r <= {FIFO_AW{1'b0}};
         trp_r <= {FIFO_AW{1'b0}};
         tcnt_r <= ZERO_C;
         rwp_r <= {FIFO_AW{1'b0}};
         rrp_r <= {FIFO_AW{1'b0}};
         rcnt_r <= ZERO_C;
      end else begin
         if (tx_flush) begin
            twp_r <= {FIFO_AW{1'b0}};
            trp_r <= {FIFO_AW{1'b0}};
            tcnt_r <= ZERO_C;
         end else begin
            if (tx_push) begin
               txm[twp_r] <= wd[8:0];
               twp_r <= twp_r + {{(FIFO_AW - 1){1'b0}}, 1'b1};
            end
            if (tx_pop) begin
               trp_r <= trp_r + {{(FIFO_AW - 1){1'b0}}, 1'b1};
            end
            tcnt_r <= tcnt_aft;
         end
         if (rx_flush) begin
            rwp_r <= {FIFO_AW{1'b0}};
            rrp_r <= {FIFO_AW{1'b0}};
            rcnt_r <= ZERO_C;
         end else begin
            if (rx_push) begin
               rxm[rwp_r] <= {rx_data, rx_parity_error, rx_framing_error};
               rwp_r <= rwp_r + {{(FIFO_AW - 1){1'b0}}, 1'b1};
            end
            if (rx_pop) begin
               rrp_r <= rrp_r + {{(FIFO_AW - 1){1'b0}}, 1'b1};
            end
            rcnt_r <= rcnt_aft;
         end
      end
   end
   // Pin and event outputs
   always @(posedge i_mclk or negedge rstn) begin
      if (!rstn) begin
         o_tx <= 1'b1;
         o_tx_oe <= 1'b0;
         o_tx_irq <= 1'b0;
         o_rx_irq <= 1'b0;
      end else begin
         o_tx_oe <= txen_r;
         if (ir_act) begin
            o_tx <= (tx_busy & ~tx_line & (tx_phase < `USC_IR_PULSE)) ^ tx_polarity_invert_r;
         end else begin
            o_tx <= tx_line ^ tx_polarity_invert_r;
         end
         case (txsel_r)
            `USC_TXI_EVERY: o_tx_irq <= tx_load;
            `USC_TXI_EMPTY: o_tx_irq <= tx_load & (tcnt_aft == ZERO_C);
            `USC_TXI_DONE: o_tx_irq <= tx_done & (tcnt_r == ZERO_C);
            default: o_tx_irq <= 1'b0;
         endcase
         case (rxsel_r)
            `USC_RXI_FULL: o_rx_irq <= rx_push & (rcnt_aft == FULL_C);
            `USC_RXI_3Q: o_rx_irq <= rx_push & (rcnt_aft == LVL3_C);
            default: o_rx_irq <= rx_push;
         endcase
      end
   end
endmodule

// file: tb/usc_top_properties.sv
// Concurrent checks on the serial transceiver top ports
`timescale 1ns/1ns
module usc_top_chk (
   input wire i_mclk,
   input wire i_resetn,
   input wire [4:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   input wire [31:0] o_avs_readdata,
   input wire o_avs_waitrequest,
   input wire i_rx,
   input wire o_tx,
   input wire o_tx_oe,
   input wire o_tx_irq,
   input wire o_rx_irq
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_resetn);
   wire sta_rd = i_avs_read && !o_avs_waitrequest && (i_avs_address == 5'h04);
   wire sta_wr = i_avs_write && !o_avs_waitrequest && (i_avs_address == 5'h04);
   a_bus_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("access not answered after one wait state");
   a_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address > 5'h10
      |-> o_avs_readdata == 32'h0) else $error("unmapped read not zero");
   a_full_not_empty: assert property (sta_rd && o_avs_readdata[9] |-> !o_avs_readdata[8])
      else $error("full and empty flags both set");
   a_flags_need_data: assert property (sta_rd && !o_avs_readdata[0] |-> o_avs_readdata[3:2] == 2'h0)
      else $error("error flags set with empty receive buffer");
   a_oe_follows: assert property (sta_wr |-> ##2 (o_tx_oe == $past(i_avs_writedata[10], 2)))
      else $error("pin enable does not follow transmit enable");
   a_tx_irq_pulse: assert property (o_tx_irq |=> !o_tx_irq)
      else $error("transmit event longer than one cycle");
   a_rx_irq_pulse: assert property (o_rx_irq |=> !o_rx_irq)
      else $error("receive event longer than one cycle");
   a_bit_hold: assert property ($changed(o_tx) && o_tx_oe && $past(o_tx_oe)
      |=> (!o_tx_oe || $stable(o_tx))[*2])
      else $error("serial level shorter than three clocks");
   c_tx_irq: cover property (o_tx_irq);
   c_rx_irq: cover property (o_rx_irq);
   c_abort: cover property ($fell(o_tx_oe));
endmodule
bind usc_top usc_top_chk usc_top_chk_i (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
   .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_rx(i_rx), .o_tx(o_tx),
   .o_tx_oe(o_tx_oe), .o_tx_irq(o_tx_irq), .o_rx_irq(o_rx_irq));

// file: tb/usc_remote.sv
// Remote serial transceiver: frame sender and line capture
`timescale 1ns/1ns
module usc_remote (
   input wire i_mclk,
   input wire i_tx,
   output logic o_rx
);
   initial o_rx = 1'b1;
   // Sends n bits LSB first, each spb clocks, then idles high
   task send(input [15:0] b, input int n, input int spb);
      begin
         for (int i = 0; i < n; i++) begin
            @(posedge i_mclk);
            o_rx <= b[i];
            repeat (spb - 1) @(posedge i_mclk);
         end
         @(posedge i_mclk);
         o_rx <= 1'b1;
         repeat (3 * spb) @(posedge i_mclk);
      end
   endtask
   // Waits for a start edge and samples n bits mid-cell
   task cap(output [31:0] b, input int n, input int spb);
      int k;
      begin
         b = 32'h0;
         k = 0;
         @(negedge i_mclk);
         while (i_tx !== 1'b0 && k < 400) begin
            @(negedge i_mclk);
            k++;
         end
         repeat (spb / 2) @(negedge i_mclk);
         for (int i = 0; i < n; i++) begin
            b[i] = i_tx;
            repeat (spb) @(negedge i_mclk);
         end
      end
   endtask
endmodule

// file: tb/tb_top.sv
// Register-level testbench of the serial transceiver
`timescale 1ns/1ns
module tb_top;
   logic i_mclk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [4:0] i_avs_address = 5'h00;
   logic [31:0] i_avs_writedata = 32'h0;
   wire [31:0] rdata;
   wire wreq, rx, tx, tx_oe, txi, rxi;
   int errors = 0;
   int tests_run = 0;
   int ntx = 0;
   int nrx = 0;
   int c;
   logic [31:0] v, b;
   always #5 i_mclk = ~i_mclk;
   usc_top #(.FIFO_AW(2)) usc_top_i (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_rx(rx), .o_tx(tx), .o_tx_oe(tx_oe),
      .o_tx_irq(txi), .o_rx_irq(rxi));
   usc_remote usc_remote_i (.i_mclk(i_mclk), .i_tx(tx), .o_rx(rx));
   always @(posedge i_mclk) begin
      if (txi === 1'b1) ntx <= ntx + 1;
      if (rxi === 1'b1) nrx <= nrx + 1;
   end
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         tests_run++;
         if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task results;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, errors);
         if (errors == 0 && tests_run > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   // Avalon access, held until waitrequest is seen low
   task acc(input w, input [4:0] a, input [31:0] d);
      int n;
      begin
         @(posedge i_mclk);
         i_avs_address <= a;
         i_avs_writedata <= d;
         i_avs_read <= !w;
         i_avs_write <= w;
         n = 0;
         do begin
            @(posedge i_mclk);
            n++;
         end while (wreq !== 1'b0 && n < 50);
         if (n >= 50) errors++;
         v = rdata;
         i_avs_read <= 1'b0;
         i_avs_write <= 1'b0;
      end
   endtask
   task wr(input [4:0] a, input [31:0] d);
      acc(1'b1, a, d);
   endtask
   task rd(input [4:0] a);
      acc(1'b0, a, 32'h0);
   endtask
   task wait_txe;
      begin
         v = 32'h0;
         for (int k = 0; k < 200 && v[8] !== 1'b1; k++) rd(5'h04);
         repeat (4) @(posedge i_mclk);
      end
   endtask
   task rxb(input [7:0] d);
      usc_remote_i.send({1'b1, d, 1'b0}, 10, 16);
   endtask
   // Two queued characters; n includes the start bit of the second
   task txchk(input [31:0] mode, input [31:0] sta, input [8:0] d, input int n, input [31:0] exp,
      input int spb, input int ni);
      begin
         wr(5'h00, mode);
         wr(5'h04, sta);
         c = ntx;
         fork
            usc_remote_i.cap(b, n, spb);
            begin
               wr(5'h08, {23'h0, d});
               wr(5'h08, {23'h0, d});
            end
         join
         chk(b & ((32'h1 << n) - 1), exp);
         wait_txe;
         chk(ntx - c, ni);
      end
   endtask
   initial begin
      #700000;
      errors++;
      $display("watchdog expired");
      results;
   end
   initial begin
      repeat (12) @(posedge i_mclk);
      i_resetn <= 1'b1;
      repeat (3) @(posedge i_mclk);
      rd(5'h04);
      chk(v, 32'h0110);
      rd(5'h00);
      chk(v, 32'h0);
      wr(5'h14, 32'hffff);
      rd(5'h14);
      chk(v, 32'h0);
      chk({31'h0, tx_oe}, 32'h0);
      $display("reset test done");
      wr(5'h04, 32'h0400);
      repeat (4) @(posedge i_mclk);
      chk({30'h0, tx_oe, tx}, 32'h3);
      wr(5'h04, 32'h4400);
      repeat (4) @(posedge i_mclk);
      chk({30'h0, tx_oe, tx}, 32'h2);
      wr(5'h00, 32'h1000);
      repeat (4) @(posedge i_mclk);
      chk({30'h0, tx_oe, tx}, 32'h3);
      wr(5'h04, 32'h0400);
      repeat (4) @(posedge i_mclk);
      chk({30'h0, tx_oe, tx}, 32'h2);
      wr(5'h00, 32'h0);
      repeat (4) @(posedge i_mclk);
      chk({30'h0, tx_oe, tx}, 32'h3);
      $display("idle level test done");
      txchk(32'h0, 32'h0400, 9'h0a5, 11, {1'b0, 1'b1, 8'ha5, 1'b0}, 16, 2);
      txchk(32'h2, 32'h2400, 9'h0a5, 12, {1'b0, 1'b1, 1'b0, 8'ha5, 1'b0}, 16, 1);
      txchk(32'h4, 32'h8400, 9'h0a5, 12, {1'b0, 1'b1, 1'b1, 8'ha5, 1'b0}, 16, 2);
      txchk(32'h6, 32'ha400, 9'h1a5, 12, {1'b0, 1'b1, 9'h1a5, 1'b0}, 16, 0);
      txchk(32'h1, 32'h0400, 9'h0a5, 12, {1'b0, 2'b11, 8'ha5, 1'b0}, 16, 2);
      txchk(32'h8, 32'h0400, 9'h03c, 11, {1'b0, 1'b1, 8'h3c, 1'b0}, 4, 2);
      txchk(32'h1008, 32'h0400, 9'h03c, 11, {1'b0, 1'b1, 8'h3c, 1'b0}, 4, 2);
      $display("transmit frame test done");
      wr(5'h00, 32'h0);
      fork
         usc_remote_i.cap(b, 24, 16);
         begin
            wr(5'h04, 32'h0c00);
            wr(5'h08, 32'h0);
            wr(5'h08, 32'h55);
         end
      join
      chk(b & 32'hffffff, {1'b1, 8'h55, 1'b0, 1'b1, 13'h0});
      wait_txe;
      chk(v & 32'h0800, 32'h0);
      $display("break test done");
      v = 32'h0;
      for (int k = 0; k < 8 && v[9] !== 1'b1; k++) begin
         wr(5'h08, k);
         rd(5'h04);
      end
      chk(v & 32'h0300, 32'h0200);
      wr(5'h04, 32'h0);
      rd(5'h04);
      chk(v & 32'h0700, 32'h0100);
      chk({31'h0, tx_oe}, 32'h0);
      $display("buffer full and abort test done");
      c = nrx;
      fork
         rxb(8'h3c);
         begin
            repeat (60) @(posedge i_mclk);
            rd(5'h04);
            chk(v & 32'h11, 32'h0);
         end
      join
      rd(5'h04);
      chk(v & 32'h1d, 32'h11);
      chk(nrx - c, 1);
      rd(5'h0c);
      chk(v, 32'h3c);
      rd(5'h04);
      chk(v & 32'h1, 32'h0);
      wr(5'h00, 32'h2);
      usc_remote_i.send({1'b1, 1'b1, 8'h3c, 1'b0}, 11, 16);
      usc_remote_i.send({1'b1, 1'b1, 8'h01, 1'b0}, 11, 16);
      rd(5'h04);
      chk(v & 32'h0d, 32'h09);
      rd(5'h0c);
      chk(v, 32'h3c);
      rd(5'h04);
      chk(v & 32'h0d, 32'h01);
      rd(5'h0c);
      chk(v, 32'h01);
      wr(5'h00, 32'h0);
      usc_remote_i.send({1'b0, 8'h3c, 1'b0}, 10, 16);
      rd(5'h04);
      chk(v & 32'h05, 32'h05);
      rd(5'h0c);
      $display("receive flag test done");
      wr(5'h00, 32'h6);
      wr(5'h04, 32'h20);
      usc_remote_i.send({1'b1, 9'h042, 1'b0}, 11, 16);
      usc_remote_i.send({1'b1, 9'h1aa, 1'b0}, 11, 16);
      rd(5'h0c);
      chk(v, 32'h1aa);
      rd(5'h04);
      chk(v & 32'h1, 32'h0);
      wr(5'h00, 32'h0);
      rxb(8'h42);
      rd(5'h0c);
      chk(v, 32'h42);
      $display("address detect test done");
      wr(5'h04, 32'h80);
      c = nrx;
      for (int k = 0; k < 3; k++) rxb(8'h10 + k);
      chk(nrx - c, 1);
      wr(5'h04, 32'hc0);
      rxb(8'h13);
      chk(nrx - c, 2);
      rxb(8'h14);
      rd(5'h04);
      chk(v & 32'h3, 32'h3);
      rd(5'h0c);
      chk(v, 32'h10);
      rxb(8'h15);
      chk(nrx - c, 2);
      for (int k = 1; k < 3; k++) begin
         rd(5'h0c);
         chk(v, 32'h10 + k);
      end
      rd(5'h04);
      chk(v & 32'h3, 32'h3);
      wr(5'h04, 32'hc0);
      rd(5'h04);
      chk(v & 32'h3, 32'h0);
      $display("overrun test done");
      results;
   end
endmodule
